// ==== drive_input_regs.svh ====
// Register offsets, reset values and function codes for the terminal decoder.
// Assumes an APB slave with 32-bit data, one aligned word per register.
//
// Notes on behaviour
// - Mode 0: terminal one closed runs forward, terminal two closed runs reverse.
// - Mode 1: terminal one is run/stop, terminal two open forward, closed reverse.
// - Three wiring modes; mode 2 starts on terminal one, stops on terminal three open.
// - Function code 0 has no effect on operation.
// - Codes 1 to 4 are the four step-speed select bits.
// - Code 5 acts like the keypad reset key.
// - Code 6 holds output speed by suspending the ramps.
// - Code 7 selects one of two ramp time sets.
// - Code 8 jog assignment is accepted only while the motor is stopped.
// - Code 9 blocks output; release triggers speed search then acceleration.
// - Codes 10 and 11 raise or lower frequency; both together halt change.
// - Each clock with a code-12 input event increments the counter by one until it saturates at full count.
// - Code 13 clears the counter and inhibits counting while active.
// - Code 14 is an external fault input.
// - Code 15 disables the closed-loop regulator while on.
// - Code 16 stops output to coast; a later change restarts from zero.
// - Code 17 locks all parameters against writes.
// - Codes 18 to 20 select run-command source; default source setting disabled.
// - Code 21 sets direction with top priority when restriction setting is zero.
// - Code 22 selects second frequency source when on.
// - Codes 23 and 24 stop forward or reverse running respectively.
// - Code 25 switches pump operation between hand and automatic mode.
// - Codes 5 and 12 are falling-edge triggered; codes 9 and 16 act on the level and also pulse on release; the other programmable codes act on the level.
`ifndef DRIVE_INPUT_REGS_SVH
`define DRIVE_INPUT_REGS_SVH

// ==========================================================
// Register offsets
`define REG_TERM3_CODE 8'h00
`define REG_TERM_STRIDE 8'h04
`define REG_WIRING_MODE 8'h10
`define REG_DRIVE_CONFIG 8'h14
`define REG_TERM_STATUS 8'h18
`define REG_COUNTER 8'h1c

// ==========================================================
// Reset values
`define RST_TERM3_CODE 8'h01
`define RST_TERM4_CODE 8'h02
`define RST_TERM5_CODE 8'h03
`define RST_TERM6_CODE 8'h04
`define RST_WIRING_MODE 2'h0
`define RST_DEFAULT_SOURCE 2'h0

// ==========================================================
// Field positions in the drive configuration register
`define CFG_SOURCE_LSB 0
`define CFG_DIR_RESTRICT_BIT 2

// ==========================================================
// Function codes
`define FN_COUNT 26
`define FN_JOG 8'h08
`define FN_RESET 5
`define FN_RAMP_HOLD 6
`define FN_RAMP_SET 7
`define FN_JOG_BIT 8
`define FN_BASE_BLOCK 9
`define FN_UP 10
`define FN_DOWN 11
`define FN_COUNT_TRIG 12
`define FN_COUNT_CLR 13
`define FN_EXT_FAULT 14
`define FN_REG_OFF 15
`define FN_SHUTOFF 16
`define FN_LOCK 17
`define FN_SRC_TERM 18
`define FN_SRC_KEYPAD 19
`define FN_SRC_COMM 20
`define FN_DIRECTION 21
`define FN_SECOND_FREQ 22
`define FN_LIMIT_FWD 23
`define FN_LIMIT_REV 24
`define FN_PUMP_MODE 25

`endif

// ==== drive_input_pkg.sv ====
// Types shared by the terminal decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package drive_input_pkg;

  typedef enum logic [1:0] {
    WIRE_TWO_FWD_REV = 2'h0,
    WIRE_TWO_RUN_DIR = 2'h1,
    WIRE_THREE = 2'h2
  } wiring_mode_t;

  typedef enum logic [1:0] {
    SRC_TERMINALS = 2'h0,
    SRC_KEYPAD = 2'h1,
    SRC_COMM = 2'h2
  } cmd_source_t;

  typedef enum logic {
    LATCH_IDLE = 1'b0,
    LATCH_RUN = 1'b1
  } run_latch_t;

endpackage : drive_input_pkg

// ==== terminal_function_decode.sv ====
// One programmable terminal: maps its function code to a one-hot vector.
// Assumes the pin is synchronous to mclk; low means contact closed.
`timescale 1ns/1ps
`default_nettype none

module terminal_function_decode #(
  parameter int CODES = 26
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] code,
  input wire logic pin_n,
  output logic [CODES-1:0] assigned,
  output logic [CODES-1:0] active,
  output logic [CODES-1:0] fell,
  output logic [CODES-1:0] rose
);

  logic prev_n;
  wire in_range;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      prev_n <= 1'b1;
    else
      prev_n <= pin_n;
  end

  // Codes outside the table decode to nothing; code 0 still sets bit 0
  assign in_range = (code < 8'(CODES));
  assign assigned = in_range ? (CODES'(1) << code) : '0;
  assign active = pin_n ? '0 : assigned;
  // Closing the contact pulls the pin low: that edge is the trigger
  assign fell = (prev_n && !pin_n) ? assigned : '0;
  assign rose = (!prev_n && pin_n) ? assigned : '0;

endmodule : terminal_function_decode

`default_nettype wire

// ==== drive_input_function_decoder.sv ====
// Digital input terminal decoder of a motor drive, with APB registers.
// Assumes synchronous, debounced terminal pins; low means contact closed.
`timescale 1ns/1ps
`default_nettype none
`include "drive_input_regs.svh"

module drive_input_function_decoder #(
  parameter int COUNTER_W = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic input_terminal_one_n,
  input wire logic input_terminal_two_n,
  input wire logic input_terminal_three_n,
  input wire logic input_terminal_four_n,
  input wire logic input_terminal_five_n,
  input wire logic input_terminal_six_n,
  input wire logic motor_stopped,
  output logic run_forward,
  output logic run_reverse,
  output logic [3:0] step_speed_select,
  output logic fault_reset,
  output logic ramp_hold,
  output logic ramp_set_select,
  output logic jog_request,
  output logic base_block,
  output logic speed_search,
  output logic freq_up,
  output logic freq_down,
  output logic external_fault,
  output logic regulator_disable,
  output logic output_shutoff,
  output logic restart_from_zero,
  output logic param_lock,
  output logic [1:0] command_source,
  output logic second_freq_source,
  output logic pump_auto_mode,
  output logic [COUNTER_W-1:0] counter_value
);

  localparam int NF = `FN_COUNT;
  localparam logic [7:0] TERM_RST [4] = '{`RST_TERM3_CODE, `RST_TERM4_CODE,
                                          `RST_TERM5_CODE, `RST_TERM6_CODE};

  // ==========================================================
  // Programmable terminal decode
  logic [7:0] term_code [4];
  wire [3:0] prog_pin_n;
  wire [NF-1:0] t_asg [4];
  wire [NF-1:0] t_act [4];
  wire [NF-1:0] t_fell [4];
  wire [NF-1:0] t_rose [4];
  wire [NF-1:0] acc_asg [5];
  wire [NF-1:0] acc_act [5];
  wire [NF-1:0] acc_fell [5];
  wire [NF-1:0] acc_rose [5];
  wire [NF-1:0] fn_asg;
  wire [NF-1:0] fn_act;
  wire [NF-1:0] fn_fell;
  wire [NF-1:0] fn_rose;

  assign prog_pin_n = {input_terminal_six_n, input_terminal_five_n,
                       input_terminal_four_n, input_terminal_three_n};
  assign acc_asg[0] = '0;
  assign acc_act[0] = '0;
  assign acc_fell[0] = '0;
  assign acc_rose[0] = '0;

  // ==========================================================
  // APB decode
  wire setup_phase;
  wire access;
  wire wr_access;
  wire [3:0] hit_term;
  wire hit_wiring;
  wire hit_config;
  wire hit_status;
  wire hit_counter;
  wire mapped;
  wire jog_refused;
  wire wiring_bad;
  wire wr_refused;
  wire wr_ok;
  wire source_locked;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_term
      terminal_function_decode #(.CODES(NF)) u_dec (
        .mclk(mclk),
        .reset_n(reset_n),
        .code(term_code[gi]),
        .pin_n(prog_pin_n[gi]),
        .assigned(t_asg[gi]),
        .active(t_act[gi]),
        .fell(t_fell[gi]),
        .rose(t_rose[gi])
      );
      assign acc_asg[gi+1] = acc_asg[gi] | t_asg[gi];
      assign acc_act[gi+1] = acc_act[gi] | t_act[gi];
      assign acc_fell[gi+1] = acc_fell[gi] | t_fell[gi];
      assign acc_rose[gi+1] = acc_rose[gi] | t_rose[gi];
      assign hit_term[gi] = (paddr == 8'(`REG_TERM3_CODE + gi * `REG_TERM_STRIDE));

      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
          term_code[gi] <= TERM_RST[gi];
        else if (wr_ok && hit_term[gi])
          term_code[gi] <= pwdata[7:0];
      end
    end
  endgenerate

  // Bit 0 is code 0 and drives nothing
  assign fn_asg = acc_asg[4] & ~NF'(1);
  assign fn_act = acc_act[4] & ~NF'(1);
  assign fn_fell = acc_fell[4];
  assign fn_rose = acc_rose[4];

  assign setup_phase = psel && !penable;
  assign access = psel && penable;
  assign wr_access = access && pwrite;
  assign hit_wiring = (paddr == `REG_WIRING_MODE);
  assign hit_config = (paddr == `REG_DRIVE_CONFIG);
  assign hit_status = (paddr == `REG_TERM_STATUS);
  assign hit_counter = (paddr == `REG_COUNTER);
  assign mapped = (|hit_term) || hit_wiring || hit_config || hit_status || hit_counter;
  // Jog may only be assigned with the motor at rest
  assign jog_refused = (|hit_term) && (pwdata[7:0] == `FN_JOG) && !motor_stopped;
  assign wiring_bad = hit_wiring && (pwdata[1:0] == 2'h3);
  assign wr_refused = param_lock || jog_refused || wiring_bad;
  assign wr_ok = wr_access && mapped && !wr_refused;
  assign source_locked = |fn_asg[`FN_SRC_COMM:`FN_SRC_TERM];
  assign pready = 1'b1;
  assign pslverr = access && (!mapped || (pwrite && wr_refused));

  // ==========================================================
  // Configuration registers
  drive_input_pkg::wiring_mode_t wiring_mode;
  drive_input_pkg::cmd_source_t default_source;
  logic dir_restrict;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      wiring_mode <= drive_input_pkg::wiring_mode_t'(`RST_WIRING_MODE);
    else if (wr_ok && hit_wiring)
      wiring_mode <= drive_input_pkg::wiring_mode_t'(pwdata[1:0]);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      default_source <= drive_input_pkg::cmd_source_t'(`RST_DEFAULT_SOURCE);
      dir_restrict <= 1'b0;
    end
    else if (wr_ok && hit_config)
    begin
      // The default source stays frozen while a source terminal is assigned
      if (!source_locked)
        default_source <= drive_input_pkg::cmd_source_t'(pwdata[`CFG_SOURCE_LSB +: 2]);
      dir_restrict <= pwdata[`CFG_DIR_RESTRICT_BIT];
    end
  end

  // ==========================================================
  // Read data, captured in the setup phase
  wire [5:0] pin_status;
  wire [31:0] next_prdata;
  logic [1:0] cfg_src_bits;

  assign cfg_src_bits = default_source;
  assign pin_status = {prog_pin_n, input_terminal_two_n, input_terminal_one_n};
  assign next_prdata =
    hit_term[0] ? {24'h000000, term_code[0]} :
    hit_term[1] ? {24'h000000, term_code[1]} :
    hit_term[2] ? {24'h000000, term_code[2]} :
    hit_term[3] ? {24'h000000, term_code[3]} :
    hit_wiring ? {30'h00000000, wiring_mode} :
    hit_config ? {29'h00000000, dir_restrict, cfg_src_bits} :
    hit_status ? {26'h0000000, pin_status} :
    hit_counter ? 32'(counter_value) : 32'h00000000;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h00000000;
    else if (setup_phase && !pwrite)
      prdata <= next_prdata;
  end

  // ==========================================================
  // Run command from the wiring terminals
  drive_input_pkg::run_latch_t latch_state;
  drive_input_pkg::run_latch_t next_latch_state;
  logic t1_prev_n;
  wire a1;
  wire a2;
  wire t1_fell;
  wire stop_open;
  logic base_run;
  logic base_rev;
  wire dir_rev;
  wire blocked;
  wire next_run_forward;
  wire next_run_reverse;

  assign a1 = !input_terminal_one_n;
  assign a2 = !input_terminal_two_n;
  assign t1_fell = t1_prev_n && input_terminal_one_n == 1'b0;
  assign stop_open = input_terminal_three_n;

  always_comb
  begin
    next_latch_state = latch_state;
    case (latch_state)
      drive_input_pkg::LATCH_IDLE:
        if (t1_fell && !stop_open)
          next_latch_state = drive_input_pkg::LATCH_RUN;
      drive_input_pkg::LATCH_RUN:
        if (stop_open)
          next_latch_state = drive_input_pkg::LATCH_IDLE;
      default:
        next_latch_state = drive_input_pkg::LATCH_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latch_state <= drive_input_pkg::LATCH_IDLE;
      t1_prev_n <= 1'b1;
    end
    else
    begin
      latch_state <= (wiring_mode == drive_input_pkg::WIRE_THREE) ? next_latch_state
                                                                 : drive_input_pkg::LATCH_IDLE;
      t1_prev_n <= input_terminal_one_n;
    end
  end

  always_comb
  begin
    case (wiring_mode)
      drive_input_pkg::WIRE_TWO_FWD_REV:
      begin
        // Both closed at once is contradictory and stops the drive
        base_run = a1 ^ a2;
        base_rev = a2;
      end
      drive_input_pkg::WIRE_TWO_RUN_DIR:
      begin
        base_run = a1;
        base_rev = a2;
      end
      drive_input_pkg::WIRE_THREE:
      begin
        // Opening the stop contact drops the run command at once, not a cycle after the latch
        base_run = (latch_state == drive_input_pkg::LATCH_RUN) && !stop_open;
        base_rev = a2;
      end
      default:
      begin
        base_run = 1'b0;
        base_rev = 1'b0;
      end
    endcase
  end

  // Direction terminal overrides the wiring when no restriction is set
  assign dir_rev = (fn_asg[`FN_DIRECTION] && !dir_restrict) ? fn_act[`FN_DIRECTION] : base_rev;
  assign blocked = fn_act[`FN_BASE_BLOCK] || fn_act[`FN_SHUTOFF];
  assign next_run_forward = base_run && !dir_rev && !blocked && !fn_act[`FN_LIMIT_FWD];
  assign next_run_reverse = base_run && dir_rev && !blocked && !fn_act[`FN_LIMIT_REV];

  // ==========================================================
  // Function outputs
  wire [1:0] next_source;

  assign next_source =
    fn_act[`FN_SRC_TERM] ? 2'(drive_input_pkg::SRC_TERMINALS) :
    fn_act[`FN_SRC_KEYPAD] ? 2'(drive_input_pkg::SRC_KEYPAD) :
    fn_act[`FN_SRC_COMM] ? 2'(drive_input_pkg::SRC_COMM) : 2'(default_source);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run_forward <= 1'b0;
      run_reverse <= 1'b0;
      step_speed_select <= 4'h0;
      fault_reset <= 1'b0;
      ramp_hold <= 1'b0;
      ramp_set_select <= 1'b0;
      jog_request <= 1'b0;
      base_block <= 1'b0;
      speed_search <= 1'b0;
      freq_up <= 1'b0;
      freq_down <= 1'b0;
      external_fault <= 1'b0;
      regulator_disable <= 1'b0;
      output_shutoff <= 1'b0;
      restart_from_zero <= 1'b0;
      param_lock <= 1'b0;
      command_source <= 2'h0;
      second_freq_source <= 1'b0;
      pump_auto_mode <= 1'b0;
    end
    else
    begin
      run_forward <= next_run_forward;
      run_reverse <= next_run_reverse;
      step_speed_select <= fn_act[4:1];
      fault_reset <= fn_fell[`FN_RESET];
      ramp_hold <= fn_act[`FN_RAMP_HOLD];
      ramp_set_select <= fn_act[`FN_RAMP_SET];
      jog_request <= fn_act[`FN_JOG_BIT];
      base_block <= fn_act[`FN_BASE_BLOCK];
      speed_search <= fn_rose[`FN_BASE_BLOCK];
      freq_up <= fn_act[`FN_UP] && !fn_act[`FN_DOWN];
      freq_down <= fn_act[`FN_DOWN] && !fn_act[`FN_UP];
      external_fault <= fn_act[`FN_EXT_FAULT];
      regulator_disable <= fn_act[`FN_REG_OFF];
      output_shutoff <= fn_act[`FN_SHUTOFF];
      restart_from_zero <= fn_rose[`FN_SHUTOFF];
      param_lock <= fn_act[`FN_LOCK];
      command_source <= next_source;
      second_freq_source <= fn_act[`FN_SECOND_FREQ];
      pump_auto_mode <= fn_act[`FN_PUMP_MODE];
    end
  end

  // ==========================================================
  // Event counter; saturates rather than wrapping to zero
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      counter_value <= '0;
    else if (fn_act[`FN_COUNT_CLR])
      counter_value <= '0;
    else if (fn_fell[`FN_COUNT_TRIG] && !(&counter_value))
      counter_value <= counter_value + COUNTER_W'(1);
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  AST_MODE0_FWD: assert property (
    wiring_mode == drive_input_pkg::WIRE_TWO_FWD_REV && a1 && !a2 && !blocked
    && !fn_asg[`FN_DIRECTION] && !fn_act[`FN_LIMIT_FWD] |=> run_forward && !run_reverse)
    else $error("mode 0 forward not driven");
  AST_MODE1_REV: assert property (
    wiring_mode == drive_input_pkg::WIRE_TWO_RUN_DIR && a1 && a2 && !blocked
    && !fn_asg[`FN_DIRECTION] && !fn_act[`FN_LIMIT_REV] |=> run_reverse)
    else $error("mode 1 reverse not driven");
  AST_THREE_STOP: assert property (
    wiring_mode == drive_input_pkg::WIRE_THREE && stop_open |=> !run_forward && !run_reverse)
    else $error("three-wire stop ignored");
  AST_STEP_BIT: assert property (
    term_code[0] == 8'h01 && !input_terminal_three_n |=> step_speed_select[0])
    else $error("step bit missing");
  AST_RESET_PULSE: assert property (
    fn_fell[`FN_RESET] |=> fault_reset ##1 (fault_reset == $past(fn_fell[`FN_RESET])))
    else $error("reset pulse wrong");
  AST_BASE_BLOCK: assert property (
    fn_act[`FN_BASE_BLOCK] |=> base_block && !run_forward && !run_reverse)
    else $error("base block leaks output");
  AST_UPDOWN_HALT: assert property (
    fn_act[`FN_UP] && fn_act[`FN_DOWN] |=> !freq_up && !freq_down)
    else $error("up and down not halted");
  AST_COUNT_INC: assert property (
    fn_fell[`FN_COUNT_TRIG] && !fn_act[`FN_COUNT_CLR] && !(&counter_value)
    |=> counter_value == $past(counter_value) + COUNTER_W'(1))
    else $error("counter missed event");
  AST_COUNT_CLR: assert property (
    fn_act[`FN_COUNT_CLR] |=> counter_value == '0)
    else $error("counter not cleared");
  AST_JOG_REFUSE: assert property (
    wr_access && hit_term[0] && pwdata[7:0] == `FN_JOG && !motor_stopped
    |-> pslverr ##1 term_code[0] == $past(term_code[0]))
    else $error("jog accepted while running");
  AST_LOCK: assert property (
    param_lock && wr_access && hit_wiring |=> $stable(wiring_mode))
    else $error("locked write took effect");

  COV_THREE_WIRE: cover property (wiring_mode == drive_input_pkg::WIRE_THREE ##1 run_forward);
  COV_COUNT: cover property (fn_fell[`FN_COUNT_TRIG] ##1 counter_value != '0);
  COV_SEARCH: cover property (base_block ##[1:20] speed_search);

endmodule : drive_input_function_decoder

`default_nettype wire

// ==== contact_bank.sv ====
// Switch contacts wired between the six input terminals and the common return.
// Assumes the bench sets the closed contacts just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module contact_bank (
  input wire logic [5:0] closed,
  output logic [5:0] pins_n
);
  // ==========================================================
  // Contacts
  // A closed contact pulls its terminal to the common return, so it reads low
  assign pins_n = ~closed;
endmodule : contact_bank

`default_nettype wire

// ==== tb_drive_input_function_decoder.sv ====
// Self-checking bench for the input terminal decoder.
// Assumes the decoder, its header and the contact model are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "drive_input_regs.svh"

module tb_drive_input_function_decoder;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, fault_reset, speed_search, restart_from_zero;
  logic motor_stopped = 1'b0;
  logic [5:0] closed = 6'h00;
  logic [5:0] pins_n;
  logic run_forward, run_reverse, ramp_hold, ramp_set_select, jog_request, base_block;
  logic freq_up, freq_down, external_fault, regulator_disable, output_shutoff, param_lock;
  logic second_freq_source, pump_auto_mode;
  logic [3:0] step_speed_select;
  logic [1:0] command_source;
  logic [15:0] counter_value;
  logic [2:0] hits;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam logic [7:0] lvl_codes [12] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0e, 8'h0f, 8'h10, 8'h11,
    8'h16, 8'h19, 8'h0b};
  wire [11:0] lv = {ramp_hold, ramp_set_select, jog_request, base_block, freq_up, external_fault,
    regulator_disable, output_shutoff, param_lock, second_freq_source, pump_auto_mode, freq_down};
  wire [1:0] run = {run_forward, run_reverse};

  contact_bank switches_u (.closed(closed), .pins_n(pins_n));

  drive_input_function_decoder dut_u (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .input_terminal_one_n(pins_n[0]), .input_terminal_two_n(pins_n[1]),
    .input_terminal_three_n(pins_n[2]), .input_terminal_four_n(pins_n[3]),
    .input_terminal_five_n(pins_n[4]), .input_terminal_six_n(pins_n[5]), .motor_stopped,
    .run_forward, .run_reverse, .step_speed_select, .fault_reset, .ramp_hold, .ramp_set_select,
    .jog_request, .base_block, .speed_search, .freq_up, .freq_down, .external_fault,
    .regulator_disable, .output_shutoff, .restart_from_zero, .param_lock, .command_source,
    .second_freq_source, .pump_auto_mode, .counter_value);

  // ==========================================================
  // Clock, timeout and shared tasks
  always #4 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end

  task finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Pulses are one cycle long, so they are gathered at every edge
  task tick(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      hits = hits | {fault_reset, speed_search, restart_from_zero};
    end
  endtask : tick

  task pins(input logic [5:0] c);
    @(posedge mclk);
    closed <= c;
    tick(4);
  endtask : pins

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("pslverr", 32'(err), 32'(e));
  endtask : wr

  // ==========================================================
  // Scenarios
  task t_regs();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("term code", rd, 32'(i + 1));
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    $display("test regs done");
  endtask : t_regs

  task t_wiring();
    pins(6'h01);
    chk("mode0 fwd", 32'(run), 32'h2);
    pins(6'h02);
    chk("mode0 rev", 32'(run), 32'h1);
    pins(6'h00);
    chk("mode0 stop", 32'(run), 32'h0);
    wr(`REG_WIRING_MODE, 32'h1, 1'b0);
    pins(6'h01);
    chk("mode1 fwd", 32'(run), 32'h2);
    pins(6'h03);
    chk("mode1 rev", 32'(run), 32'h1);
    pins(6'h02);
    chk("mode1 stop", 32'(run), 32'h0);
    wr(`REG_WIRING_MODE, 32'h2, 1'b0);
    pins(6'h04);
    pins(6'h05);
    pins(6'h04);
    chk("mode2 start", 32'(run), 32'h2);
    pins(6'h06);
    chk("mode2 rev", 32'(run), 32'h1);
    pins(6'h02);
    chk("mode2 stop", 32'(run), 32'h0);
    wr(`REG_WIRING_MODE, 32'h3, 1'b1);
    wr(`REG_WIRING_MODE, 32'h0, 1'b0);
    pins(6'h24);
    chk("step bits", 32'(step_speed_select), 32'h9);
    pins(6'h00);
    $display("test wiring done");
  endtask : t_wiring

  task t_count();
    wr(8'h00, 32'hc, 1'b0);
    wr(8'h04, 32'hd, 1'b0);
    repeat (2)
    begin
      pins(6'h04);
      pins(6'h00);
    end
    chk("count", 32'(counter_value), 32'h2);
    pins(6'h08);
    pins(6'h0c);
    pins(6'h08);
    chk("cleared", 32'(counter_value), 32'h0);
    pins(6'h00);
    pins(6'h04);
    apb(1'b0, `REG_COUNTER, 32'h0);
    chk("count read", rd, 32'h1);
    pins(6'h00);
    $display("test count done");
  endtask : t_count

  task t_codes();
    motor_stopped <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      wr(8'h08, 32'(lvl_codes[i]), 1'b0);
      hits = 3'h0;
      pins(6'h10);
      chk("level", 32'(lv), 32'(12'h800 >> i));
      if (lvl_codes[i] == 8'h11)
        wr(`REG_WIRING_MODE, 32'h1, 1'b1);
      pins(6'h00);
      chk("release", 32'(hits), 32'({1'b0, i == 3, i == 7}));
    end
    wr(8'h08, 32'h5, 1'b0);
    hits = 3'h0;
    pins(6'h10);
    chk("reset pulse", 32'(hits), 32'h4);
    wr(8'h08, 32'h0, 1'b0);
    pins(6'h30);
    chk("code0", 32'({lv, step_speed_select}), 32'h8);
    motor_stopped <= 1'b0;
    pins(6'h00);
    wr(8'h00, 32'h8, 1'b1);
    apb(1'b0, 8'h00, 32'h0);
    chk("jog refused", rd, 32'hc);
    $display("test codes done");
  endtask : t_codes

  task t_source();
    wr(8'h08, 32'ha, 1'b0);
    wr(8'h0c, 32'hb, 1'b0);
    pins(6'h30);
    chk("up down", 32'({freq_up, freq_down}), 32'h0);
    wr(`REG_DRIVE_CONFIG, 32'h1, 1'b0);
    for (int c = 18; c < 21; c++)
    begin
      wr(8'h08, 32'(c), 1'b0);
      pins(6'h10);
      chk("source on", 32'(command_source), 32'(c - 18));
    end
    pins(6'h00);
    wr(`REG_DRIVE_CONFIG, 32'h2, 1'b0);
    apb(1'b0, `REG_DRIVE_CONFIG, 32'h0);
    chk("source off", {rd[31:2], command_source}, 32'h1);
    wr(8'h08, 32'h15, 1'b0);
    pins(6'h11);
    chk("direction", 32'(run), 32'h1);
    wr(8'h08, 32'h17, 1'b0);
    tick(2);
    chk("fwd limit", 32'(run), 32'h0);
    wr(8'h08, 32'h18, 1'b0);
    pins(6'h12);
    chk("rev limit", 32'(run), 32'h0);
    pins(6'h00);
    $display("test source done");
  endtask : t_source

  initial
  begin
    hits = 3'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_wiring();
    t_count();
    t_codes();
    t_source();
    finish_test();
  end
endmodule : tb_drive_input_function_decoder

`default_nettype wire
